// ===== logic/spf_cfg.svh
`ifndef SPF_CFG_SVH
`define SPF_CFG_SVH
// How it works
// - pin b1 alternate output carries slave data, master data or uart transmit.
// - serial controller output on b1 only when timer channel 1 is off or unremapped.
// - twi data on b1 is open-drain, chosen by the b1 function field.
// - timer channel 1 on b1 needs remap bit 4, output enable and the port a alternate select.
// - timer channel 1 input comes from b1 while remap bit 4 is clear.
// - b2 feeds spi master input, spi slave input or uart receive by mode.
// - twi clock on b2 is open-drain, needs channel 2 off or remap bit 5 clear.
// - timer channel 2 drives b2 with remap bit 5, enable and alternate select.
// - timer channel 2 input comes from b2 while remap bit 5 is set.
// - debug clock pin is serial wire clock, or jtag clock with pull-down.
// - c2 carries jtag data out in jtag mode unless debug config bit 5 frees it.
// - c2 outputs async trace in serial wire mode when enabled and selected, pull-up on.
// - debug port is jtag after reset or external reset low; a request selects serial wire.

// ----------------------------------------
// function field codes and positions
// ----------------------------------------
`define SPF_CFG_ALT_OUT 4'h9
`define SPF_CFG_ALT_OD 4'hd
`define SPF_PB1_FLD 7:4
`define SPF_PB2_FLD 11:8
`define SPF_PA_T1_FLD 7:4
`define SPF_PC2_FLD 11:8
`define SPF_REMAP_CH1 4
`define SPF_REMAP_CH2 5
`define SPF_DBG_GPIO_BIT 5
`define SPF_OE_CH1 0
`define SPF_OE_CH2 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define SPF_RST_IDLE_HIGH 1'h1
`define SPF_RST_GPIO_OWN 3'h7
`endif

// ===== logic/spf_pkg.sv
package spf_pkg;
  typedef enum logic [1:0] {
    SPF_SC_OFF = 2'h0,
    SPF_SC_UART = 2'h1,
    SPF_SC_SPI = 2'h2,
    SPF_SC_TWI = 2'h3
  } spf_sc_mode_t;

  typedef enum logic {
    SPF_DBG_JTAG = 1'h0,
    SPF_DBG_SWD = 1'h1
  } spf_dbg_t;

  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
    logic pull_down;
  } spf_pin_t;

  typedef struct packed {
    spf_dbg_t dbg;
    spf_pin_t pb1;
    spf_pin_t pb2;
    spf_pin_t dck;
    spf_pin_t pc2;
    logic spi_in_master;
    logic spi_out_master;
    logic uart_rx;
    logic twi_data;
    logic twi_clock;
    logic tim1_in;
    logic tim2_in;
    logic tck;
    logic swclk;
    logic [2:0] gpio_own;
  } spf_state_t;
endpackage

// ===== logic/spf_pin_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "spf_cfg.svh"
module spf_pin_select import spf_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [15:0] i_port_b_low_function_cfg,
  input wire logic [15:0] i_port_a_low_function_cfg,
  input wire logic [15:0] i_port_c_low_function_cfg,
  input wire logic [7:0] i_debug_pin_cfg,
  input wire logic [1:0] i_timer_two_output_enable,
  input wire logic [7:0] i_timer_two_remap_bits,
  input wire spf_sc_mode_t i_sc_one_mode_select,
  input wire logic i_sc_one_spi_role,
  input wire spf_pin_t i_gpio_pb1,
  input wire spf_pin_t i_gpio_pb2,
  input wire spf_pin_t i_gpio_pc2,
  input wire logic i_sc_one_spi_in_master,
  input wire logic i_sc_one_spi_out_master,
  input wire logic i_sc_one_uart_tx,
  input wire logic i_sc_one_twi_data_low,
  input wire logic i_sc_one_twi_clock_low,
  input wire logic i_timer_two_chan1,
  input wire logic i_timer_two_chan2,
  input wire logic i_jtag_test_data_out,
  input wire logic i_jtag_tdo_en,
  input wire logic i_swo_trace,
  input wire logic i_swo_enable,
  input wire logic i_swd_switch_req,
  input wire logic i_external_reset_n,
  input wire logic i_port_b_pin1_in,
  input wire logic i_port_b_pin2_in,
  input wire logic i_jtag_test_clock_pin_in,
  input wire logic i_port_c_pin2_in,
  output spf_pin_t o_port_b_pin1,
  output spf_pin_t o_port_b_pin2,
  output spf_pin_t o_jtag_test_clock_pin,
  output spf_pin_t o_port_c_pin2,
  output logic o_sc_one_spi_in_master,
  output logic o_sc_one_spi_out_master,
  output logic o_sc_one_uart_rx,
  output logic o_sc_one_twi_data,
  output logic o_sc_one_twi_clock,
  output logic o_timer_two_chan1,
  output logic o_timer_two_chan2,
  output logic o_jtag_test_clock,
  output logic o_swclk,
  output logic o_debug_swd_mode,
  output logic [2:0] o_gpio_own
);

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic fld_is(input logic [3:0] fld, input logic [3:0] code);
    fld_is = (fld == code);
  endfunction

  localparam spf_pin_t PIN_IDLE = '{out: 1'h0, oe: 1'h0, pull_up: 1'h0, pull_down: 1'h0};
  localparam spf_pin_t PIN_DCK_RST = '{out: 1'h0, oe: 1'h0, pull_up: 1'h0, pull_down: 1'h1};

  spf_state_t state_r;
  spf_state_t state_nxt;

  logic pb1_alt;
  logic pb1_od;
  logic pb2_alt;
  logic pb2_od;
  logic tim1_claim;
  logic tim2_claim;
  logic sc1_pb1_ok;
  logic sc1_pb2_ok;
  logic is_spi;
  logic is_uart;
  logic is_twi;
  logic swo_sel;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    pb1_alt = fld_is(i_port_b_low_function_cfg[`SPF_PB1_FLD], `SPF_CFG_ALT_OUT);
    pb1_od = fld_is(i_port_b_low_function_cfg[`SPF_PB1_FLD], `SPF_CFG_ALT_OD);
    pb2_alt = fld_is(i_port_b_low_function_cfg[`SPF_PB2_FLD], `SPF_CFG_ALT_OUT);
    pb2_od = fld_is(i_port_b_low_function_cfg[`SPF_PB2_FLD], `SPF_CFG_ALT_OD);
    is_spi = (i_sc_one_mode_select == SPF_SC_SPI);
    is_uart = (i_sc_one_mode_select == SPF_SC_UART);
    is_twi = (i_sc_one_mode_select == SPF_SC_TWI);
    tim1_claim = i_timer_two_remap_bits[`SPF_REMAP_CH1] & i_timer_two_output_enable[`SPF_OE_CH1] &
                 fld_is(i_port_a_low_function_cfg[`SPF_PA_T1_FLD], `SPF_CFG_ALT_OUT);
    // timer output enable with remap bit blocks the serial controller on the same pin, even without a claim
    sc1_pb1_ok = !(i_timer_two_output_enable[`SPF_OE_CH1] & i_timer_two_remap_bits[`SPF_REMAP_CH1]);
    tim2_claim = i_timer_two_remap_bits[`SPF_REMAP_CH2] & i_timer_two_output_enable[`SPF_OE_CH2] &
                 pb2_alt;
    sc1_pb2_ok = !(i_timer_two_output_enable[`SPF_OE_CH2] & i_timer_two_remap_bits[`SPF_REMAP_CH2]);

    // debug port mode; external reset always wins over a switch request
    case (state_r.dbg)
      SPF_DBG_JTAG: begin
        if (i_external_reset_n && i_swd_switch_req) begin
          state_nxt.dbg = SPF_DBG_SWD;
        end
      end
      SPF_DBG_SWD: begin
        if (!i_external_reset_n) begin
          state_nxt.dbg = SPF_DBG_JTAG;
        end
      end
      default: begin
        state_nxt.dbg = SPF_DBG_JTAG;
      end
    endcase

    // port b pin 1
    state_nxt.gpio_own[0] = 1'h0;
    if (tim1_claim) begin
      state_nxt.pb1 = '{out: i_timer_two_chan1, oe: 1'h1, pull_up: 1'h0, pull_down: 1'h0};
    end else if (sc1_pb1_ok && pb1_alt && is_spi) begin
      state_nxt.pb1 = '{out: (i_sc_one_spi_role ? i_sc_one_spi_out_master : i_sc_one_spi_in_master),
                        oe: 1'h1, pull_up: 1'h0, pull_down: 1'h0};
    end else if (sc1_pb1_ok && pb1_alt && is_uart) begin
      state_nxt.pb1 = '{out: i_sc_one_uart_tx, oe: 1'h1, pull_up: 1'h0, pull_down: 1'h0};
    end else if (sc1_pb1_ok && pb1_od && is_twi) begin
      // open-drain: only ever pulls low
      state_nxt.pb1 = '{out: 1'h0, oe: i_sc_one_twi_data_low, pull_up: 1'h0, pull_down: 1'h0};
    end else begin
      state_nxt.pb1 = i_gpio_pb1;
      state_nxt.gpio_own[0] = 1'h1;
    end

    // port b pin 2
    state_nxt.gpio_own[1] = 1'h0;
    if (tim2_claim) begin
      state_nxt.pb2 = '{out: i_timer_two_chan2, oe: 1'h1, pull_up: 1'h0, pull_down: 1'h0};
    end else if (sc1_pb2_ok && pb2_od && is_twi) begin
      state_nxt.pb2 = '{out: 1'h0, oe: i_sc_one_twi_clock_low, pull_up: 1'h0, pull_down: 1'h0};
    end else begin
      state_nxt.pb2 = i_gpio_pb2;
      state_nxt.gpio_own[1] = 1'h1;
    end

    // serial controller inputs; unused inputs rest at their idle level
    state_nxt.spi_in_master = is_spi & i_sc_one_spi_role & i_port_b_pin2_in;
    state_nxt.spi_out_master = is_spi & !i_sc_one_spi_role & i_port_b_pin2_in;
    state_nxt.uart_rx = is_uart ? i_port_b_pin2_in : 1'h1;
    state_nxt.twi_data = is_twi ? i_port_b_pin1_in : 1'h1;
    state_nxt.twi_clock = is_twi ? i_port_b_pin2_in : 1'h1;
    state_nxt.tim1_in = !i_timer_two_remap_bits[`SPF_REMAP_CH1] & i_port_b_pin1_in;
    state_nxt.tim2_in = i_timer_two_remap_bits[`SPF_REMAP_CH2] & i_port_b_pin2_in;

    // debug clock pin is input only; pull-down only in jtag mode
    state_nxt.dck = PIN_IDLE;
    state_nxt.dck.pull_down = (state_r.dbg == SPF_DBG_JTAG);
    state_nxt.tck = (state_r.dbg == SPF_DBG_JTAG) & i_jtag_test_clock_pin_in;
    state_nxt.swclk = (state_r.dbg == SPF_DBG_SWD) & i_jtag_test_clock_pin_in;

    // port c pin 2; the gpio bit overrides every debug use
    swo_sel = (state_r.dbg == SPF_DBG_SWD) & i_swo_enable &
              fld_is(i_port_c_low_function_cfg[`SPF_PC2_FLD], `SPF_CFG_ALT_OUT);
    state_nxt.gpio_own[2] = 1'h0;
    if (i_debug_pin_cfg[`SPF_DBG_GPIO_BIT]) begin
      state_nxt.pc2 = i_gpio_pc2;
      state_nxt.gpio_own[2] = 1'h1;
    end else if (state_r.dbg == SPF_DBG_JTAG) begin
      state_nxt.pc2 = '{out: i_jtag_test_data_out, oe: i_jtag_tdo_en, pull_up: 1'h0, pull_down: 1'h0};
    end else if (swo_sel) begin
      state_nxt.pc2 = '{out: i_swo_trace, oe: 1'h1, pull_up: 1'h1, pull_down: 1'h0};
    end else begin
      state_nxt.pc2 = i_gpio_pc2;
      state_nxt.gpio_own[2] = 1'h1;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r.dbg <= SPF_DBG_JTAG;
      state_r.pb1 <= PIN_IDLE;
      state_r.pb2 <= PIN_IDLE;
      state_r.dck <= PIN_DCK_RST;
      state_r.pc2 <= PIN_IDLE;
      state_r.spi_in_master <= 1'h0;
      state_r.spi_out_master <= 1'h0;
      state_r.uart_rx <= `SPF_RST_IDLE_HIGH;
      state_r.twi_data <= `SPF_RST_IDLE_HIGH;
      state_r.twi_clock <= `SPF_RST_IDLE_HIGH;
      state_r.tim1_in <= 1'h0;
      state_r.tim2_in <= 1'h0;
      state_r.tck <= 1'h0;
      state_r.swclk <= 1'h0;
      state_r.gpio_own <= `SPF_RST_GPIO_OWN;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_port_b_pin1 = state_r.pb1;
  assign o_port_b_pin2 = state_r.pb2;
  assign o_jtag_test_clock_pin = state_r.dck;
  assign o_port_c_pin2 = state_r.pc2;
  assign o_sc_one_spi_in_master = state_r.spi_in_master;
  assign o_sc_one_spi_out_master = state_r.spi_out_master;
  assign o_sc_one_uart_rx = state_r.uart_rx;
  assign o_sc_one_twi_data = state_r.twi_data;
  assign o_sc_one_twi_clock = state_r.twi_clock;
  assign o_timer_two_chan1 = state_r.tim1_in;
  assign o_timer_two_chan2 = state_r.tim2_in;
  assign o_jtag_test_clock = state_r.tck;
  assign o_swclk = state_r.swclk;
  assign o_debug_swd_mode = (state_r.dbg == SPF_DBG_SWD);
  assign o_gpio_own = state_r.gpio_own;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  pb1_sc_out_a: assert property (
    (pb1_alt && sc1_pb1_ok && !tim1_claim && (is_spi || is_uart)) |=>
      (o_port_b_pin1.oe && o_port_b_pin1.out == ($past(is_uart) ? $past(i_sc_one_uart_tx) :
       $past(i_sc_one_spi_role) ? $past(i_sc_one_spi_out_master) : $past(i_sc_one_spi_in_master))))
    else $error("pb1 serial output wrong");
  pb1_timer_block_a: assert property (
    (i_timer_two_output_enable[`SPF_OE_CH1] && i_timer_two_remap_bits[`SPF_REMAP_CH1] && !tim1_claim) |=>
      o_gpio_own[0] && o_port_b_pin1 == $past(i_gpio_pb1))
    else $error("pb1 serial not blocked by timer");
  pb1_twi_od_a: assert property (
    (pb1_od && is_twi && sc1_pb1_ok) |=>
      (!o_port_b_pin1.out && o_port_b_pin1.oe == $past(i_sc_one_twi_data_low)))
    else $error("pb1 twi not open-drain");
  pb1_timer_out_a: assert property (
    tim1_claim |=> (o_port_b_pin1.oe && o_port_b_pin1.out == $past(i_timer_two_chan1) && !o_gpio_own[0]))
    else $error("pb1 timer output wrong");
  tim1_input_a: assert property (
    ##1 o_timer_two_chan1 == ($past(i_port_b_pin1_in) && !$past(i_timer_two_remap_bits[`SPF_REMAP_CH1])))
    else $error("timer ch1 input wrong");
  pb2_sc_input_a: assert property (
    is_uart |=> (o_sc_one_uart_rx == $past(i_port_b_pin2_in) && !o_sc_one_spi_in_master && !o_sc_one_spi_out_master))
    else $error("pb2 uart receive wrong");
  pb2_spi_input_a: assert property (
    (is_spi && i_sc_one_spi_role) |=> (o_sc_one_spi_in_master == $past(i_port_b_pin2_in) && !o_sc_one_spi_out_master))
    else $error("pb2 spi master input wrong");
  pb2_twi_clock_a: assert property (
    (pb2_od && is_twi && sc1_pb2_ok) |=>
      (!o_port_b_pin2.out && o_port_b_pin2.oe == $past(i_sc_one_twi_clock_low) && o_sc_one_twi_clock == $past(i_port_b_pin2_in)))
    else $error("pb2 twi clock wrong");
  pb2_timer_out_a: assert property (
    tim2_claim |=> (o_port_b_pin2.oe && o_port_b_pin2.out == $past(i_timer_two_chan2)))
    else $error("pb2 timer output wrong");
  tim2_input_a: assert property (
    ##1 o_timer_two_chan2 == ($past(i_port_b_pin2_in) && $past(i_timer_two_remap_bits[`SPF_REMAP_CH2])))
    else $error("timer ch2 input wrong");
  dck_pull_mode_a: assert property (
    ##1 (o_jtag_test_clock_pin.pull_down == !$past(o_debug_swd_mode) && !o_jtag_test_clock_pin.oe &&
         (o_swclk | o_jtag_test_clock) == $past(i_jtag_test_clock_pin_in)))
    else $error("debug clock pin wrong");
  pc2_jtag_tdo_a: assert property (
    (!i_debug_pin_cfg[`SPF_DBG_GPIO_BIT] && !o_debug_swd_mode) |=>
      (o_port_c_pin2.out == $past(i_jtag_test_data_out) && o_port_c_pin2.oe == $past(i_jtag_tdo_en)))
    else $error("pc2 jtag data out wrong");
  pc2_swo_a: assert property (
    (!i_debug_pin_cfg[`SPF_DBG_GPIO_BIT] && swo_sel) |=>
      (o_port_c_pin2.oe && o_port_c_pin2.pull_up && o_port_c_pin2.out == $past(i_swo_trace)))
    else $error("pc2 trace output wrong");
  dbg_ext_reset_a: assert property (
    (!i_external_reset_n)[*2] |-> !o_debug_swd_mode)
    else $error("debug port left jtag under reset");
  dbg_switch_a: assert property (
    (!o_debug_swd_mode && i_swd_switch_req && i_external_reset_n) |=> o_debug_swd_mode)
    else $error("switch request ignored");
  pin_gpio_own_a: assert property (
    (!tim2_claim && !(pb2_od && is_twi && sc1_pb2_ok)) |=> (o_gpio_own[1] && o_port_b_pin2 == $past(i_gpio_pb2)))
    else $error("pb2 not returned to gpio");

  pb2_spi_slave_a: assert property (
    (is_spi && !i_sc_one_spi_role) |=> (o_sc_one_spi_out_master == $past(i_port_b_pin2_in) && !o_sc_one_spi_in_master))
    else $error("pb2 spi slave input wrong");
  sc_idle_in_a: assert property (
    (i_sc_one_mode_select == SPF_SC_OFF) |=> (o_sc_one_uart_rx && o_sc_one_twi_data && o_sc_one_twi_clock &&
      !o_sc_one_spi_in_master && !o_sc_one_spi_out_master))
    else $error("idle serial inputs not at rest");
  pb1_twi_in_a: assert property (
    is_twi |=> (o_sc_one_twi_data == $past(i_port_b_pin1_in)))
    else $error("pb1 twi data input wrong");
  pb2_timer_block_a: assert property (
    (i_timer_two_output_enable[`SPF_OE_CH2] && i_timer_two_remap_bits[`SPF_REMAP_CH2] && !tim2_claim) |=>
      (o_gpio_own[1] && o_port_b_pin2 == $past(i_gpio_pb2)))
    else $error("pb2 twi clock not blocked by timer");
  dbg_swd_hold_a: assert property (
    (o_debug_swd_mode && i_external_reset_n) |=> o_debug_swd_mode)
    else $error("serial wire mode dropped");

  // ----------------------------------------
  // fall-back checks
  // ----------------------------------------
  // a pin nobody claims must mirror the gpio request, or the gpio logic loses control
  pb1_gpio_own_a: assert property (
    (!tim1_claim && !(sc1_pb1_ok && ((pb1_alt && (is_spi || is_uart)) || (pb1_od && is_twi)))) |=>
      (o_gpio_own[0] && o_port_b_pin1 == $past(i_gpio_pb1)))
    else $error("pb1 not returned to gpio");
  pc2_gpio_bit_a: assert property (
    i_debug_pin_cfg[`SPF_DBG_GPIO_BIT] |=> (o_gpio_own[2] && o_port_c_pin2 == $past(i_gpio_pc2)))
    else $error("pc2 gpio bit ignored");
  pc2_swd_gpio_a: assert property (
    (!i_debug_pin_cfg[`SPF_DBG_GPIO_BIT] && o_debug_swd_mode && !swo_sel) |=>
      (o_gpio_own[2] && o_port_c_pin2 == $past(i_gpio_pc2)))
    else $error("pc2 not returned to gpio");

  uart_tx_c: cover property (is_uart && pb1_alt && sc1_pb1_ok ##1 o_port_b_pin1.oe);
  spi_master_c: cover property (is_spi && i_sc_one_spi_role && pb1_alt && sc1_pb1_ok ##1 o_port_b_pin1.oe);
  twi_bus_c: cover property (is_twi && pb1_od && pb2_od ##1 o_port_b_pin1.oe && o_port_b_pin2.oe);
  timer_remap_c: cover property (tim1_claim && tim2_claim);
  swd_trace_c: cover property (o_debug_swd_mode && swo_sel ##1 o_port_c_pin2.pull_up);

endmodule
`default_nettype wire

// ===== sim/spf_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module spf_far_side import spf_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire spf_pin_t [3:0] i_pins,
  input wire logic [3:0] i_far_en,
  input wire logic [3:0] i_far_val,
  output logic [3:0] o_pad
);
  // ----------------------------------------
  // pad resolution, index 0 pb1, 1 pb2, 2 clock, 3 pc2
  // ----------------------------------------
  logic wobble_r;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wobble_r <= 1'h0;
    end else begin
      wobble_r <= ~wobble_r;
    end
  end

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (i_pins[k].oe && i_far_en[k]) begin
        o_pad[k] = i_pins[k].out & i_far_val[k]; // wired low on an open-drain bus
      end else if (i_pins[k].oe) begin
        o_pad[k] = i_pins[k].out;
      end else if (i_far_en[k]) begin
        o_pad[k] = i_far_val[k]; // debugger clock or peripheral data
      end else if (i_pins[k].pull_up) begin
        o_pad[k] = 1'h1;
      end else if (i_pins[k].pull_down) begin
        o_pad[k] = 1'h0; // idle test clock held low
      end else begin
        o_pad[k] = wobble_r; // floating pad must not look like a held value
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import spf_pkg::*;;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [15:0] cfg_b = 16'h0, cfg_a = 16'h0, cfg_c = 16'h0;
  logic [7:0] dcfg = 8'h0, remap = 8'h0;
  logic [1:0] toe = 2'h0;
  spf_sc_mode_t mode = SPF_SC_OFF;
  logic role = 1'h0, s_in = 1'h0, s_out = 1'h0, utx = 1'h0, twd = 1'h0, twc = 1'h0, ch1 = 1'h0, ch2 = 1'h0;
  logic tdo = 1'h0, tdo_en = 1'h0, swo = 1'h0, swo_en = 1'h0, req = 1'h0, xrst_n = 1'h1;
  spf_pin_t g1 = 4'h0, g2 = 4'h0, g3 = 4'h0;
  logic [3:0] far_en = 4'h0, far_val = 4'h0, pad;
  spf_pin_t p1, p2, pck, pc2;
  logic ms_in, ms_out, urx, twi_d, twi_c, t1, t2, jck, swclk, swd;
  logic [2:0] own;
  int err_count = 0, num_checks = 0;

  spf_pin_select dut (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_port_b_low_function_cfg(cfg_b), .i_port_a_low_function_cfg(cfg_a),
    .i_port_c_low_function_cfg(cfg_c), .i_debug_pin_cfg(dcfg), .i_timer_two_output_enable(toe),
    .i_timer_two_remap_bits(remap), .i_sc_one_mode_select(mode), .i_sc_one_spi_role(role),
    .i_gpio_pb1(g1), .i_gpio_pb2(g2), .i_gpio_pc2(g3), .i_sc_one_spi_in_master(s_in),
    .i_sc_one_spi_out_master(s_out), .i_sc_one_uart_tx(utx), .i_sc_one_twi_data_low(twd),
    .i_sc_one_twi_clock_low(twc), .i_timer_two_chan1(ch1), .i_timer_two_chan2(ch2),
    .i_jtag_test_data_out(tdo), .i_jtag_tdo_en(tdo_en), .i_swo_trace(swo), .i_swo_enable(swo_en),
    .i_swd_switch_req(req), .i_external_reset_n(xrst_n), .i_port_b_pin1_in(pad[0]), .i_port_b_pin2_in(pad[1]),
    .i_jtag_test_clock_pin_in(pad[2]), .i_port_c_pin2_in(pad[3]), .o_port_b_pin1(p1), .o_port_b_pin2(p2),
    .o_jtag_test_clock_pin(pck), .o_port_c_pin2(pc2), .o_sc_one_spi_in_master(ms_in),
    .o_sc_one_spi_out_master(ms_out), .o_sc_one_uart_rx(urx), .o_sc_one_twi_data(twi_d),
    .o_sc_one_twi_clock(twi_c), .o_timer_two_chan1(t1), .o_timer_two_chan2(t2), .o_jtag_test_clock(jck),
    .o_swclk(swclk), .o_debug_swd_mode(swd), .o_gpio_own(own)
  );

  spf_far_side far (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_pins({pc2, pck, p2, p1}), .i_far_en(far_en), .i_far_val(far_val),
    .o_pad(pad)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // covers the two-cycle path through the debug mode register
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (2000) @(posedge clk);
    err_count++;
    wrap_up;
  end

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    chk(pck, 4'h1);
    chk({1'h0, own}, 4'h7);
    chk({3'h0, swd}, 4'h0);
    rst_n <= 1'h1;
    @(posedge clk);
    cfg_b <= 16'h0090;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      mode <= (k == 2) ? SPF_SC_UART : SPF_SC_SPI;
      role <= (k == 1);
      s_in <= (k == 0);
      s_out <= (k == 1);
      utx <= (k == 2);
      settle;
      chk(p1, 4'hc);
      chk({3'h0, own[0]}, 4'h0);
    end
    @(posedge clk);
    toe <= 2'h1;
    remap <= 8'h10;
    cfg_a <= 16'h0090;
    g1 <= 4'ha;
    settle;
    chk(p1, 4'h4);
    @(posedge clk);
    ch1 <= 1'h1;
    cfg_a <= 16'h0;
    settle;
    chk(p1, 4'ha);
    chk({3'h0, own[0]}, 4'h1);
    @(posedge clk);
    remap <= 8'h0;
    settle;
    chk(p1, 4'hc);
    @(posedge clk);
    mode <= SPF_SC_OFF;
    cfg_b <= 16'h0;
    toe <= 2'h0;
    g1 <= 4'h0;
    far_en <= 4'h3;
    far_val <= 4'h3;
    remap <= 8'h20;
    settle;
    chk({2'h0, t1, t2}, 4'h3);
    @(posedge clk);
    remap <= 8'h10;
    settle;
    chk({2'h0, t1, t2}, 4'h0);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      mode <= (k == 2) ? SPF_SC_UART : SPF_SC_SPI;
      role <= (k == 0);
      far_val <= (k == 2) ? 4'h1 : 4'h3;
      settle;
      chk({1'h0, ms_in, ms_out, urx}, (k == 0) ? 4'h5 : (k == 1) ? 4'h3 : 4'h0);
    end
    @(posedge clk);
    mode <= SPF_SC_TWI;
    remap <= 8'h0;
    cfg_b <= 16'h0dd0;
    far_val <= 4'h3;
    twd <= 1'h1;
    twc <= 1'h1;
    settle;
    chk(p1, 4'h4);
    chk(p2, 4'h4);
    chk({2'h0, twi_d, twi_c}, 4'h0);
    @(posedge clk);
    twd <= 1'h0;
    toe <= 2'h2;
    remap <= 8'h20;
    g2 <= 4'h6;
    settle;
    chk(p1, 4'h0);
    chk(p2, 4'h6);
    chk({2'h0, twi_d, twi_c}, 4'h2);
    @(posedge clk);
    cfg_b <= 16'h0900;
    ch2 <= 1'h1;
    settle;
    chk(p2, 4'hc);
    @(posedge clk);
    remap <= 8'h0;
    mode <= SPF_SC_OFF;
    settle;
    chk(p2, 4'h6);
    chk({3'h0, own[1]}, 4'h1);
    @(posedge clk);
    tdo <= 1'h1;
    tdo_en <= 1'h1;
    g3 <= 4'h9;
    settle;
    chk(pc2, 4'hc);
    @(posedge clk);
    dcfg <= 8'h20;
    settle;
    chk(pc2, 4'h9);
    chk({3'h0, own[2]}, 4'h1);
    @(posedge clk);
    dcfg <= 8'h0;
    far_en <= 4'h4;
    far_val <= 4'h4;
    settle;
    chk({2'h0, jck, swclk}, 4'h2);
    @(posedge clk);
    xrst_n <= 1'h0;
    req <= 1'h1;
    @(posedge clk);
    req <= 1'h0;
    xrst_n <= 1'h1;
    settle;
    chk({3'h0, swd}, 4'h0);
    @(posedge clk);
    req <= 1'h1;
    cfg_c <= 16'h0900;
    swo_en <= 1'h1;
    swo <= 1'h1;
    @(posedge clk);
    req <= 1'h0;
    settle;
    chk({3'h0, swd}, 4'h1);
    chk(pck, 4'h0);
    chk({2'h0, jck, swclk}, 4'h1);
    chk(pc2, 4'he);
    @(posedge clk);
    swo_en <= 1'h0;
    settle;
    chk(pc2, 4'h9);
    @(posedge clk);
    xrst_n <= 1'h0;
    settle;
    chk({3'h0, swd}, 4'h0);
    chk(pck, 4'h1);
    wrap_up;
  end
endmodule
`default_nettype wire
